// [design/pll_synth_divider.sv]
// PLL synthesizer core: input select, divider, reference, comparator, error pin.
// Assumes register-file and put/get strobes from the CPU on clk_i, and the
// selected oscillator, after its input amplifier, as the clock osc_clk_i.
`timescale 1ns/1ps
`include "pll_synth_map.svh"

module pll_synth_divider #(
   parameter int REF_SHIFT = 0
) (
   // System clock and power-on reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Oscillator link clock
   input  wire logic       osc_clk_i,
   // Chip enable pin
   input  wire logic       ce_i,
   // Register file port
   input  wire logic [7:0] rf_addr_i,
   input  wire logic       rf_wr_i,
   input  wire logic       rf_rd_i,
   input  wire logic [3:0] rf_wdata_i,
   output logic      [3:0] rf_rdata_o,
   // Peripheral transfer
   input  wire logic [7:0] peri_addr_i,
   input  wire logic       put_i,
   input  wire logic       get_i,
   // Pins
   output logic            low_band_pulldown_o,
   output logic            high_band_pulldown_o,
   output logic            loop_error_output_o,
   output logic            loop_error_output_oe_o
);

   pll_synth_pkg::sys_state_t  s_reg, s_next;
   pll_synth_pkg::link_state_t l_reg, l_next;
   logic                       lrst_s1, lrst_s2;
   logic                       active, run, fr_tick, fn_edge, lock_rd;
   logic [15:0]                ref_period;

   // Reference period in system clocks; prohibited codes give zero
   function automatic logic [15:0] cmp_period(input logic [3:0] sel);
      logic [31:0] c;
      c = 32'h0;
      unique case (sel)
         4'h0: c = `CYC_OF_HZ(1250);
         4'h1: c = `CYC_OF_HZ(2500);
         4'h2: c = `CYC_OF_HZ(5000);
         4'h3: c = `CYC_OF_HZ(10000);
         4'h4: c = `CYC_OF_HZ(6250);
         4'h5: c = `CYC_OF_HZ(12500);
         4'h6: c = `CYC_OF_HZ(25000);
         4'h7: c = `CYC_OF_HZ(50000);
         4'h8: c = `CYC_OF_HZ(3000);
         4'hc: c = `CYC_OF_HZ(1000);
         4'hd: c = `CYC_OF_HZ(9000);
         4'he: c = `CYC_OF_HZ(100000);
         default: c = 32'h0;
      endcase
      c = c >> REF_SHIFT;
      return c[15:0];
   endfunction

   assign ref_period = cmp_period(s_reg.cmp_sel);
   // Only chip enable and a legal select code let the loop run
   assign active  = s_reg.ce_s2 && (ref_period != 16'h0);
   assign run     = active && (s_reg.mode != pll_synth_pkg::DIV_INPUTS_OFF);
   assign fr_tick = active && (s_reg.ref_cnt == 16'h0);
   assign fn_edge = s_reg.fn_s2 ^ s_reg.fn_d;
   assign lock_rd = rf_rd_i && (rf_addr_i == `ADDR_LOCK_LOSS);

   always_comb begin
      s_next       = s_reg;
      s_next.ce_s1 = ce_i;
      s_next.ce_s2 = s_reg.ce_s1;
      s_next.fn_s1 = l_reg.fn_tgl;
      s_next.fn_s2 = s_reg.fn_s1;
      s_next.fn_d  = s_reg.fn_s2;
      // Register file writes
      if (rf_wr_i) begin
         unique case (rf_addr_i)
            `ADDR_MODE_SEL: begin
               s_next.mode    = pll_synth_pkg::div_mode_t'(rf_wdata_i[1:0]);
               s_next.cfg_tgl = ~s_reg.cfg_tgl;
            end
            `ADDR_CMP_SEL:  s_next.cmp_sel = rf_wdata_i;
            `ADDR_BUF_NIB3: s_next.xfer_buf[15:12] = rf_wdata_i;
            `ADDR_BUF_NIB2: s_next.xfer_buf[11:8]  = rf_wdata_i;
            `ADDR_BUF_NIB1: s_next.xfer_buf[7:4]   = rf_wdata_i;
            `ADDR_BUF_NIB0: s_next.xfer_buf[3:0]   = rf_wdata_i;
            default: ;
         endcase
      end
      // Peripheral transfers; a get after a nibble write wins the buffer
      if (put_i && (peri_addr_i == `PERI_RATIO)) begin
         s_next.ratio   = s_reg.xfer_buf;
         // One toggle even when a mode write falls in the same cycle
         s_next.cfg_tgl = ~s_reg.cfg_tgl;
      end
      if (get_i && (peri_addr_i == `PERI_RATIO)) begin
         s_next.xfer_buf = s_reg.ratio;
      end
      // Register reads
      s_next.rdata = 4'h0;
      if (rf_rd_i) begin
         unique case (rf_addr_i)
            `ADDR_LOCK_LOSS: s_next.rdata[`LOCK_LOSS_BIT] = s_reg.lock_loss;
            `ADDR_MODE_SEL:  s_next.rdata = {2'b00, s_reg.mode};
            `ADDR_CMP_SEL:   s_next.rdata = s_reg.cmp_sel;
            `ADDR_BUF_NIB3:  s_next.rdata = s_reg.xfer_buf[15:12];
            `ADDR_BUF_NIB2:  s_next.rdata = s_reg.xfer_buf[11:8];
            `ADDR_BUF_NIB1:  s_next.rdata = s_reg.xfer_buf[7:4];
            `ADDR_BUF_NIB0:  s_next.rdata = s_reg.xfer_buf[3:0];
            default: ;
         endcase
      end
      // Reference generator
      // Parked at zero, so the first tick comes as soon as the loop runs
      if (!active) begin
         s_next.ref_cnt = 16'h0;
      end else if (fr_tick) begin
         s_next.ref_cnt = ref_period - 16'h1;
      end else begin
         s_next.ref_cnt = s_reg.ref_cnt - 16'h1;
      end
      // Phase-frequency comparator
      if (!active) begin
         s_next.up_req        = 1'b0;
         s_next.lower_request = 1'b0;
      end else begin
         s_next.up_req        = s_reg.up_req || fr_tick;
         s_next.lower_request = s_reg.lower_request || fn_edge;
         if (s_next.up_req && s_next.lower_request) begin
            s_next.up_req        = 1'b0;
            s_next.lower_request = 1'b0;
         end
      end
      // Lock-loss flag; a set in the read cycle wins over the clear
      if (lock_rd) begin
         s_next.lock_loss = 1'b0;
      end
      if (!active) begin
         s_next.seen = 1'b0;
      end else if (fr_tick) begin
         if (s_reg.seen || s_reg.up_req || s_reg.lower_request) begin
            s_next.lock_loss = 1'b1;
         end
         s_next.seen = 1'b0;
      end else begin
         s_next.seen = s_reg.seen || s_reg.up_req || s_reg.lower_request;
      end
      // Charge pump: up drives low, down drives high
      s_next.err    = s_reg.lower_request;
      s_next.err_oe = active && (s_reg.up_req ^ s_reg.lower_request);
      // Input select pull-downs
      s_next.pd_low  = 1'b1;
      s_next.pd_high = 1'b1;
      if (active) begin
         unique case (s_reg.mode)
            pll_synth_pkg::DIV_DIRECT,
            pll_synth_pkg::DIV_SWALLOW_HF:  s_next.pd_low  = 1'b0;
            pll_synth_pkg::DIV_SWALLOW_VHF: s_next.pd_high = 1'b0;
            pll_synth_pkg::DIV_INPUTS_OFF:  ;
         endcase
      end
   end

   // Mode and select are kept while chip enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg         <= '0;
         s_reg.mode    <= pll_synth_pkg::div_mode_t'(`MODE_RST);
         s_reg.cmp_sel <= `CMP_RST;
         s_reg.pd_low  <= 1'b1;
         s_reg.pd_high <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rf_rdata_o             = s_reg.rdata;
   assign low_band_pulldown_o    = s_reg.pd_low;
   assign high_band_pulldown_o   = s_reg.pd_high;
   assign loop_error_output_o    = s_reg.err;
   assign loop_error_output_oe_o = s_reg.err_oe;

   // Reset carried into the oscillator domain
   always_ff @(posedge osc_clk_i) begin
      lrst_s1 <= rst_i;
      lrst_s2 <= lrst_s1;
   end

   // Divider, oscillator domain. Ratio and mode are taken a few link cycles
   // after the toggle; software must not rewrite them faster than that.
   always_comb begin
      l_next        = l_reg;
      l_next.run_s1 = run;
      l_next.run_s2 = l_reg.run_s1;
      l_next.cfg_s1 = s_reg.cfg_tgl;
      l_next.cfg_s2 = l_reg.cfg_s1;
      l_next.cfg_d  = l_reg.cfg_s2;
      if (l_reg.cfg_s2 != l_reg.cfg_d) begin
         l_next.ratio = s_reg.ratio;
         l_next.mode  = s_reg.mode;
      end
      if (!l_reg.run_s2) begin
         l_next.prog_cnt    = l_reg.ratio[15:4];
         l_next.swallow_cnt = l_reg.ratio[3:0];
         l_next.psc_cnt     = (l_reg.ratio[3:0] != 4'h0) ? `PSC_LOAD_17 : `PSC_LOAD_16;
      end else if (l_reg.mode == pll_synth_pkg::DIV_DIRECT) begin
         // Programmable counter alone; low nibble ignored
         if (l_reg.prog_cnt <= 12'h1) begin
            l_next.prog_cnt = l_reg.ratio[15:4];
            l_next.fn_tgl   = ~l_reg.fn_tgl;
         end else begin
            l_next.prog_cnt = l_reg.prog_cnt - 12'h1;
         end
      end else if (l_reg.psc_cnt != 5'h0) begin
         l_next.psc_cnt = l_reg.psc_cnt - 5'h1;
      end else begin
         // One prescaler period done
         if (l_reg.swallow_cnt != 4'h0) begin
            l_next.swallow_cnt = l_reg.swallow_cnt - 4'h1;
         end
         if (l_reg.prog_cnt <= 12'h1) begin
            l_next.prog_cnt    = l_reg.ratio[15:4];
            l_next.swallow_cnt = l_reg.ratio[3:0];
            l_next.fn_tgl      = ~l_reg.fn_tgl;
         end else begin
            l_next.prog_cnt = l_reg.prog_cnt - 12'h1;
         end
         l_next.psc_cnt = (l_next.swallow_cnt != 4'h0) ? `PSC_LOAD_17 : `PSC_LOAD_16;
      end
   end

   always_ff @(posedge osc_clk_i) begin
      if (lrst_s2) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   // Checks, system and oscillator domains
   sequence put_seq;
      put_i && (peri_addr_i == `PERI_RATIO);
   endsequence

   sequence get_seq;
      get_i && !put_i && (peri_addr_i == `PERI_RATIO);
   endsequence

   ce_off_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_reg.ce_s2 |=> !loop_error_output_oe_o && low_band_pulldown_o && high_band_pulldown_o)
      else $error("output not idle with chip enable low");

   sel_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.cmp_sel == `CMP_OFF) |=> !loop_error_output_oe_o && low_band_pulldown_o)
      else $error("disabled select code left the loop running");

   vhf_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active && (s_reg.mode == pll_synth_pkg::DIV_SWALLOW_VHF)
      |=> low_band_pulldown_o && !high_band_pulldown_o)
      else $error("wrong pull-downs in VHF mode");

   put_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
      put_seq |=> s_reg.ratio == $past(s_reg.xfer_buf))
      else $error("put did not copy buffer");

   get_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
      get_seq |=> s_reg.xfer_buf == $past(s_reg.ratio))
      else $error("get did not copy ratio");

   lock_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      lock_rd && !fr_tick |=> !s_reg.lock_loss)
      else $error("read did not clear lock-loss flag");

   lock_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fr_tick && (s_reg.up_req || s_reg.lower_request) |=> s_reg.lock_loss)
      else $error("lock loss not flagged");

   up_drives_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active && s_reg.up_req && !s_reg.lower_request
      |=> loop_error_output_oe_o && !loop_error_output_o)
      else $error("up request did not drive low");

   no_req_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !active |=> !s_reg.up_req && !s_reg.lower_request)
      else $error("request while disabled");

   psc_mod_a: assert property (@(posedge osc_clk_i) disable iff (lrst_s2)
      l_reg.run_s2 && (l_reg.mode != pll_synth_pkg::DIV_DIRECT) && (l_reg.psc_cnt == 5'h0)
      |=> (l_reg.psc_cnt == `PSC_LOAD_17) == (l_reg.swallow_cnt != 4'h0))
      else $error("prescaler modulus does not follow swallow counter");

   direct_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active && (s_reg.mode == pll_synth_pkg::DIV_DIRECT)
      |=> !low_band_pulldown_o && high_band_pulldown_o)
      else $error("wrong pull-downs in direct mode");

   hf_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active && (s_reg.mode == pll_synth_pkg::DIV_SWALLOW_HF)
      |=> !low_band_pulldown_o && high_band_pulldown_o)
      else $error("wrong pull-downs in HF mode");

   off_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active && (s_reg.mode == pll_synth_pkg::DIV_INPUTS_OFF)
      |=> low_band_pulldown_o && high_band_pulldown_o)
      else $error("inputs not pulled down in input-disable mode");

   down_drives_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active && s_reg.lower_request && !s_reg.up_req
      |=> loop_error_output_oe_o && loop_error_output_o)
      else $error("down request did not drive high");

   equal_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.up_req == s_reg.lower_request) |=> !loop_error_output_oe_o)
      else $error("error pin driven without a single request");

   ref_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fr_tick |=> s_reg.ref_cnt == $past(ref_period) - 16'h1)
      else $error("reference counter not reloaded with its period");

   rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !rf_rd_i |=> rf_rdata_o == 4'h0)
      else $error("read data not zero without a read");

   mode_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rf_rd_i && (rf_addr_i == `ADDR_MODE_SEL)
      |=> (rf_rdata_o[1:0] == $past(s_reg.mode)) && (rf_rdata_o[3:2] == 2'b00))
      else $error("mode read returned wrong code");

   lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !lock_rd && !fr_tick |=> s_reg.lock_loss == $past(s_reg.lock_loss))
      else $error("lock-loss flag changed without tick or read");

   psc_count_a: assert property (@(posedge osc_clk_i) disable iff (lrst_s2)
      l_reg.run_s2 && (l_reg.mode != pll_synth_pkg::DIV_DIRECT) && (l_reg.psc_cnt != 5'h0)
      |=> l_reg.psc_cnt == $past(l_reg.psc_cnt) - 5'h1)
      else $error("prescaler did not count down");

   swallow_dec_a: assert property (@(posedge osc_clk_i) disable iff (lrst_s2)
      l_reg.run_s2 && (l_reg.mode != pll_synth_pkg::DIV_DIRECT) && (l_reg.psc_cnt == 5'h0)
      && (l_reg.swallow_cnt != 4'h0) && (l_reg.prog_cnt > 12'h1)
      |=> l_reg.swallow_cnt == $past(l_reg.swallow_cnt) - 4'h1)
      else $error("swallow counter did not count down");

   direct_reload_a: assert property (@(posedge osc_clk_i) disable iff (lrst_s2)
      l_reg.run_s2 && (l_reg.mode == pll_synth_pkg::DIV_DIRECT) && (l_reg.prog_cnt <= 12'h1)
      |=> ({l_reg.prog_cnt, 4'h0} == ($past(l_reg.ratio) & 16'hfff0))
      && (l_reg.fn_tgl != $past(l_reg.fn_tgl)))
      else $error("direct divider did not reload and toggle");

   stop_load_a: assert property (@(posedge osc_clk_i) disable iff (lrst_s2)
      !l_reg.run_s2 |=> {l_reg.prog_cnt, l_reg.swallow_cnt} == $past(l_reg.ratio))
      else $error("stopped divider not loaded from ratio");

endmodule

// [pkg/pll_synth_map.svh]
// Register addresses, reset values and timing counts of the PLL synthesizer.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef PLL_SYNTH_MAP_SVH
`define PLL_SYNTH_MAP_SVH

`define ADDR_LOCK_LOSS    8'h05
`define ADDR_BUF_NIB3     8'h0c
`define ADDR_BUF_NIB2     8'h0d
`define ADDR_BUF_NIB1     8'h0e
`define ADDR_BUF_NIB0     8'h0f
`define ADDR_MODE_SEL     8'h21
`define ADDR_CMP_SEL      8'h31
`define PERI_RATIO        8'h41

`define MODE_RST          2'h0
`define CMP_RST           4'hf
`define CMP_OFF           4'hf
`define LOCK_LOSS_BIT     0

// Prescaler reload values: a count of 16 is 17 input cycles
`define PSC_LOAD_17       5'h10
`define PSC_LOAD_16       5'h0f

`define CLK_HZ            40000000
`define CYC_OF_HZ(f)      (`CLK_HZ / (f))

`endif

// [pkg/pll_synth_pkg.sv]
// Types shared by the PLL synthesizer core.
// Assumes the map header for widths of counts.
package pll_synth_pkg;

   typedef enum logic [1:0] {
      DIV_DIRECT,
      DIV_SWALLOW_HF,
      DIV_SWALLOW_VHF,
      DIV_INPUTS_OFF
   } div_mode_t;

   typedef struct packed {
      logic        ce_s1;
      logic        ce_s2;
      div_mode_t   mode;
      logic [3:0]  cmp_sel;
      logic [15:0] xfer_buf;
      logic [15:0] ratio;
      logic        cfg_tgl;
      logic        fn_s1;
      logic        fn_s2;
      logic        fn_d;
      logic [15:0] ref_cnt;
      logic        up_req;
      logic        lower_request;
      logic        seen;
      logic        lock_loss;
      logic [3:0]  rdata;
      logic        err;
      logic        err_oe;
      logic        pd_low;
      logic        pd_high;
   } sys_state_t;

   typedef struct packed {
      logic        run_s1;
      logic        run_s2;
      logic        cfg_s1;
      logic        cfg_s2;
      logic        cfg_d;
      div_mode_t   mode;
      logic [15:0] ratio;
      logic [11:0] prog_cnt;
      logic [3:0]  swallow_cnt;
      logic [4:0]  psc_cnt;
      logic        fn_tgl;
   } link_state_t;

endpackage

// [verification/testbench.sv]
// Self-checking bench for the PLL synthesizer core.
// Assumes the map header and the loop filter model beside it.
`timescale 1ns/1ps
`include "pll_synth_map.svh"

module testbench;
   localparam int SHIFT = 4;
   localparam int PER   = (`CYC_OF_HZ(2500)) >> SHIFT;
   logic       clk_i;
   logic       rst_i;
   logic       osc_clk_i;
   logic       ce_i;
   logic [7:0] rf_addr_i;
   logic       rf_wr_i;
   logic       rf_rd_i;
   logic [3:0] rf_wdata_i;
   logic [3:0] rf_rdata_o;
   logic [7:0] peri_addr_i;
   logic       put_i;
   logic       get_i;
   logic       lo_pd;
   logic       hi_pd;
   logic       err;
   logic       oe;
   logic       lvl_clr;
   int         lvl;
   int         fails;
   int         n_checks;

   pll_synth_divider #(.REF_SHIFT(SHIFT)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .osc_clk_i(osc_clk_i), .ce_i(ce_i),
      .rf_addr_i(rf_addr_i), .rf_wr_i(rf_wr_i), .rf_rd_i(rf_rd_i),
      .rf_wdata_i(rf_wdata_i), .rf_rdata_o(rf_rdata_o), .peri_addr_i(peri_addr_i),
      .put_i(put_i), .get_i(get_i), .low_band_pulldown_o(lo_pd),
      .high_band_pulldown_o(hi_pd), .loop_error_output_o(err),
      .loop_error_output_oe_o(oe));

   vco_lpf_model partner (.osc_clk_o(osc_clk_i), .err_i(err), .oe_i(oe),
      .clr_i(lvl_clr), .level_o(lvl));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic test_done;
      if (fails == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      rf_addr_i = a;
      rf_wdata_i = d;
      rf_wr_i = 1'b1;
      tick(1);
      rf_wr_i = 1'b0;
      tick(1);
   endtask

   // Read data is registered, so it is looked at one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [3:0] e);
      rf_addr_i = a;
      rf_rd_i = 1'b1;
      tick(1);
      rf_rd_i = 1'b0;
      chk({12'h0, rf_rdata_o}, {12'h0, e});
      tick(1);
   endtask

   task automatic xfer(input logic [7:0] a, input logic p, input logic g);
      peri_addr_i = a;
      put_i = p;
      get_i = g;
      tick(1);
      put_i = 1'b0;
      get_i = 1'b0;
      tick(1);
   endtask

   task automatic ld_buf(input logic [15:0] v);
      for (int i = 0; i < 4; i++) wr(8'(8'h0c + i), v[15 - 4 * i -: 4]);
   endtask

   task automatic rd_buf(input logic [15:0] e);
      for (int i = 0; i < 4; i++) rd(8'(8'h0c + i), e[15 - 4 * i -: 4]);
   endtask

   task automatic pins(input logic l, input logic h, input logic o);
      chk({13'h0, lo_pd, hi_pd, oe}, {13'h0, l, h, o});
   endtask

   // Charge trend over many reference periods shows the divide ratio used
   task automatic trend(input logic [1:0] m, input logic up);
      wr(8'h21, {2'h0, m});
      tick(200);
      lvl_clr = 1'b1;
      tick(10);
      lvl_clr = 1'b0;
      tick(8000);
      chk({15'h0, lvl < 0}, {15'h0, up});
   endtask

   initial begin
      #(25.0 * 60000);
      fails++;
      test_done();
   end

   initial begin
      logic [3:0] off_codes [4];
      logic [1:0] pd_tab [4];
      logic [3:0] sel_codes [12];
      int         sel_hz [12];
      off_codes = '{4'h9, 4'ha, 4'hb, 4'hf};
      pd_tab = '{2'b01, 2'b01, 2'b10, 2'b11};
      sel_codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd, 4'he};
      sel_hz = '{1250, 2500, 5000, 10000, 6250, 12500, 25000, 50000, 3000, 1000, 9000, 100000};
      fails = 0;
      n_checks = 0;
      rst_i = 1'b1;
      ce_i = 1'b1;
      rf_addr_i = 8'h00;
      rf_wr_i = 1'b0;
      rf_rd_i = 1'b0;
      rf_wdata_i = 4'h0;
      peri_addr_i = 8'h00;
      put_i = 1'b0;
      get_i = 1'b0;
      lvl_clr = 1'b0;
      tick(10);
      rst_i = 1'b0;
      rd(8'h21, 4'h0);
      rd(8'h31, 4'hf);
      rd(8'h05, 4'h0);
      pins(1'b1, 1'b1, 1'b0);
      wr(8'h05, 4'hf);
      rd(8'h05, 4'h0);
      rd(8'h07, 4'h0);
      ld_buf(16'ha5c3);
      rd_buf(16'ha5c3);
      xfer(8'h41, 1'b1, 1'b0);
      ld_buf(16'h0000);
      xfer(8'h40, 1'b0, 1'b1);
      rd_buf(16'h0000);
      xfer(8'h41, 1'b0, 1'b1);
      rd_buf(16'ha5c3);
      ld_buf(16'h0100);
      xfer(8'h41, 1'b1, 1'b0);
      wr(8'h31, 4'h1);
      for (int m = 0; m < 4; m++) begin
         wr(8'h21, 4'(m));
         rd(8'h21, 4'(m));
         tick(10);
         chk({14'h0, lo_pd, hi_pd}, {14'h0, pd_tab[m]});
      end
      tick(2 * PER + 100);
      pins(1'b1, 1'b1, 1'b1);
      chk({15'h0, err}, 16'h0000);
      wr(8'h31, 4'hf);
      tick(2 * PER + 100);
      pins(1'b1, 1'b1, 1'b0);
      rd(8'h05, 4'h1);
      rd(8'h05, 4'h0);
      // Inputs off: steady up request sets the flag one period after enabling
      foreach (sel_codes[i]) begin
         wr(8'h31, sel_codes[i]);
         tick(((`CYC_OF_HZ(sel_hz[i])) >> SHIFT) - 2);
         rd(8'h05, 4'h0);
         rd(8'h05, 4'h1);
         wr(8'h31, 4'hf);
      end
      wr(8'h21, 4'h0);
      foreach (off_codes[i]) begin
         wr(8'h31, off_codes[i]);
         tick(10);
         pins(1'b1, 1'b1, 1'b0);
      end
      wr(8'h31, 4'h1);
      wr(8'h21, 4'h2);
      tick(10);
      chk({14'h0, lo_pd, hi_pd}, 16'h0002);
      ce_i = 1'b0;
      tick(10);
      pins(1'b1, 1'b1, 1'b0);
      ce_i = 1'b1;
      tick(10);
      rd(8'h21, 4'h2);
      rd(8'h31, 4'h1);
      trend(2'h0, 1'b0);
      trend(2'h1, 1'b1);
      trend(2'h2, 1'b1);
      test_done();
   end
endmodule

// [verification/vco_lpf_model.sv]
// Loop filter and oscillator model for the synthesizer error pin.
// Assumes the oscillator runs free; its output is the link clock.
`timescale 1ns/1ps

module vco_lpf_model #(
   parameter realtime HALF = 62.5
) (
   // Oscillator output
   output logic osc_clk_o,
   // Error pin as seen by the filter
   input  wire logic err_i,
   input  wire logic oe_i,
   // Filter discharge and charge level
   input  wire logic clr_i,
   output int        level_o
);
   // Odd start offset keeps the two clocks out of phase
   initial begin
      osc_clk_o = 1'b0;
      #17;
      forever #HALF osc_clk_o = ~osc_clk_o;
   end

   // Floating pin leaves charge untouched; driven levels pump it
   always @(posedge osc_clk_o) begin
      if (clr_i) begin
         level_o <= 0;
      end else if (oe_i) begin
         level_o <= err_i ? level_o + 1 : level_o - 1;
      end
   end
endmodule
